// file: psmc_map.vh
// constants for the pseudo-sram mode configuration block
`ifndef PSMC_MAP_VH
`define PSMC_MAP_VH
// mode word field positions on the address pins
`define PSMC_W_MODE       19
`define PSMC_B_STYLE      18
`define PSMC_B_DRV_HI     17
`define PSMC_B_DRV_LO     16
`define PSMC_B_OPM_HI     15
`define PSMC_B_OPM_LO     14
`define PSMC_B_RDYPOL     13
`define PSMC_B_WRAP       12
`define PSMC_B_LAT_HI     11
`define PSMC_B_LAT_LO     9
`define PSMC_B_RDYTIM     8
`define PSMC_B_BST_HI     7
`define PSMC_B_BST_LO     5
`define PSMC_B_DSLEEP     4
`define PSMC_B_RRET       3
`define PSMC_B_HALF       2
`define PSMC_B_SIZE_HI    1
`define PSMC_B_SIZE_LO    0
// default word: fixed, full drive, page mode, ws high, wrap, lat 3, prior, len4, dpd/par off
`define PSMC_DEFAULT      19'h0005C
// magic software sequence addresses
`define PSMC_MAGIC_A      24'h0FFFFF
`define PSMC_MAGIC_B      24'hFFFEFF
`define PSMC_MAGIC_CNT    3'h4
// field codes
`define PSMC_DRV_FULL     2'h0
`define PSMC_DRV_HALF     2'h1
`define PSMC_DRV_QTR      2'h2
`define PSMC_OPM_PAGE     2'h0
`define PSMC_OPM_BURST    2'h1
`define PSMC_BST_4        3'h2
`define PSMC_BST_8        3'h3
`define PSMC_BST_16       3'h4
`define PSMC_BST_32       3'h5
`define PSMC_BST_CONT     3'h7
`define PSMC_SZ_FULL      2'h0
`define PSMC_SZ_HALF      2'h2
`define PSMC_SZ_QTR       2'h3
// timing
`define PSMC_LP_NS        500
`define PSMC_CLK_NS       100
`define PSMC_BC_NS        1200
`endif

// file: psmc_sync.v
// two-flop synchroniser for a single pin
module psmc_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire clk_sys_i,
  input  wire nrst_i,
  input  wire pin_i,
  output wire pin_o
);
  reg meta_ff; // first stage, read only by sync_ff
  reg sync_ff; // stable copy
  // metastability guard
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end
  assign pin_o = sync_ff;
endmodule // psmc_sync

// file: psmc_decode.v
// decodes the stored mode word into usable settings
`include "psmc_map.vh"
module psmc_decode (
  input  wire [18:0] mode_i,
  output reg  [3:0]  latency_o,
  output reg  [5:0]  burst_len_o,
  output reg         burst_cont_o,
  output reg  [1:0]  drive_o,
  output reg         mode_bad_o
);
  wire [2:0] lat_w = mode_i[`PSMC_B_LAT_HI:`PSMC_B_LAT_LO]; // latency code
  wire [2:0] bst_w = mode_i[`PSMC_B_BST_HI:`PSMC_B_BST_LO]; // burst code
  wire [1:0] drv_w = mode_i[`PSMC_B_DRV_HI:`PSMC_B_DRV_LO]; // drive code
  wire [1:0] opm_w = mode_i[`PSMC_B_OPM_HI:`PSMC_B_OPM_LO]; // mode code
  wire [1:0] sz_w  = mode_i[`PSMC_B_SIZE_HI:`PSMC_B_SIZE_LO];
  // latency table, 100 is the odd one out
  always @* begin
    case (lat_w)
      3'h4:    latency_o = 4'h2;
      3'h0:    latency_o = 4'h3;
      3'h1:    latency_o = 4'h4;
      3'h2:    latency_o = 4'h5;
      3'h3:    latency_o = 4'h6;
      3'h5:    latency_o = 4'h7;
      3'h6:    latency_o = 4'h8;
      default: latency_o = 4'h9;
    endcase
  end
  // burst length table, zero length marks reserved or continuous
  always @* begin
    burst_cont_o = 1'b0;
    case (bst_w)
      `PSMC_BST_4:    burst_len_o = 6'h04;
      `PSMC_BST_8:    burst_len_o = 6'h08;
      `PSMC_BST_16:   burst_len_o = 6'h10;
      `PSMC_BST_32:   burst_len_o = 6'h20;
      `PSMC_BST_CONT: begin
        burst_len_o  = 6'h00;
        burst_cont_o = 1'b1;
      end
      default:        burst_len_o = 6'h00;
    endcase
  end
  // drive code passes through; reserved 11 falls back to full
  always @* begin
    drive_o = (drv_w == 2'h3) ? `PSMC_DRV_FULL : drv_w;
  end
  // reserved code flag for the controller's benefit
  always @* begin
    mode_bad_o = (drv_w == 2'h3) || opm_w[1] || (sz_w == 2'h1) ||
                 (bst_w == 3'h0) || (bst_w == 3'h1) || (bst_w == 3'h6);
  end
endmodule // psmc_decode

// file: psmc_core.v
// mode word loader and low-power state control of the pseudo-sram
`include "psmc_map.vh"
// Behaviour
// - two load paths: strobe pin, magic reads
// - address bits 19 to 23 ignored for the word, compared in magic reads
// - mode word fields taken from address pins
// - style and drive level decoded
// - page mode or burst read selected
// - ready polarity picks valid level
// - wrap bit picks wrap or linear
// - latency code mapped to clock count
// - ready timing early or with data
// - burst code mapped to length
// - no refresh during continuous burst
// - deep sleep and partial refresh enables
// - retained half and size select
// - defaults at reset and deep exit
// - four reads, magic addresses, then word
// - pin load ends on release of cs, cfg or we, or of both byte selects
// - only retained portion refreshed
// - deep power-down beats partial refresh
// - long strobe low enters partial refresh
// - long strobe low enters deep sleep
// - deep exit reloads defaults
// - defaults use full drive
module psmc_core #(
  parameter LP_NS  = `PSMC_LP_NS,   // low-power entry hold time
  parameter CLK_NS = `PSMC_CLK_NS   // clock period
) (
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire [23:0] addr_i,           // address pins
  input  wire        chip_select_n_i,
  input  wire        high_byte_sel_n_i,
  input  wire        low_byte_sel_n_i,
  input  wire        cfg_strobe_n_i,
  input  wire        write_strobe_n_i,
  input  wire        out_enable_n_i,
  input  wire        data_ready_i,     // read data valid from the datapath
  input  wire        burst_active_i,   // a burst is under way
  output reg  [18:0] mode_o,           // current mode word
  output wire        first_access_style_o,
  output wire [1:0]  drive_level_o,
  output wire [1:0]  operating_mode_sel_o,
  output wire        wrap_o,
  output wire [3:0]  latency_o,
  output wire [5:0]  burst_len_o,
  output wire        burst_cont_o,
  output wire        ready_early_o,
  output reg         ready_pin_o,      // valid indicator after polarity
  output wire        refresh_en_o,
  output wire [1:0]  refresh_region_o, // 0 full,1 bottom half,2 top half
  output wire [1:0]  refresh_quarter_o,
  output wire        refresh_part_o,
  output wire        partial_o,
  output wire        deep_o,
  output wire        data_lost_o,
  output wire        config_load_o,
  output wire        mode_bad_o
);
  // low-power hold count, least time so round up; the strobe must stay low
  // at least this long, so a short count would enter low power too early
  localparam integer LP_CYC_I = (LP_NS + CLK_NS - 1) / CLK_NS;
  localparam [7:0]   LP_CYC   = LP_CYC_I[7:0];
  // power states
  localparam [1:0] ST_STBY = 2'h0;
  localparam [1:0] ST_PAR  = 2'h1;
  localparam [1:0] ST_DPD  = 2'h2;

  wire cs_n_w, hb_n_w, lb_n_w, ps_n_w, we_n_w, oe_n_w; // synchronised pins
  reg  [23:0] a1_ff;          // address first stage
  reg  [23:0] addr_ff;        // synchronised address
  reg  [1:0]  pwr_ff;         // power state
  reg  [1:0]  nxt_pwr;
  reg  [7:0]  lp_cnt_ff;      // strobe-low time in standby
  reg  [2:0]  seq_ff;         // magic read progress
  reg         cs_d_ff;        // last chip select
  reg         arm_ff;         // pin load armed
  reg         lost_ff;        // data invalid since deep sleep
  reg         rdy_d_ff;       // delayed ready for at-data timing
  reg         load_ff;        // load pulse
  reg         rd_seen_ff;     // read seen while selected

  // synchronise control pins, idle high
  psmc_sync #(
    .RST_VAL(1'b1)
  ) u_cs (
    .clk_sys_i(clk_sys_i),
    .nrst_i   (nrst_i),
    .pin_i    (chip_select_n_i),
    .pin_o    (cs_n_w)
  );

  psmc_sync #(
    .RST_VAL(1'b1)
  ) u_hb (
    .clk_sys_i(clk_sys_i),
    .nrst_i   (nrst_i),
    .pin_i    (high_byte_sel_n_i),
    .pin_o    (hb_n_w)
  );

  psmc_sync #(
    .RST_VAL(1'b1)
  ) u_lb (
    .clk_sys_i(clk_sys_i),
    .nrst_i   (nrst_i),
    .pin_i    (low_byte_sel_n_i),
    .pin_o    (lb_n_w)
  );

  psmc_sync #(
    .RST_VAL(1'b1)
  ) u_ps (
    .clk_sys_i(clk_sys_i),
    .nrst_i   (nrst_i),
    .pin_i    (cfg_strobe_n_i),
    .pin_o    (ps_n_w)
  );

  psmc_sync #(
    .RST_VAL(1'b1)
  ) u_we (
    .clk_sys_i(clk_sys_i),
    .nrst_i   (nrst_i),
    .pin_i    (write_strobe_n_i),
    .pin_o    (we_n_w)
  );

  psmc_sync #(
    .RST_VAL(1'b1)
  ) u_oe (
    .clk_sys_i(clk_sys_i),
    .nrst_i   (nrst_i),
    .pin_i    (out_enable_n_i),
    .pin_o    (oe_n_w)
  );

  // address bus synchroniser; the word must be held stable, so a wide
  // two-stage copy is safe
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      a1_ff   <= 24'h000000;
      addr_ff <= 24'h000000;
    end else begin
      a1_ff   <= addr_i;
      addr_ff <= a1_ff;
    end
  end

  // all pins share the same two-clock lag, so their relative order is kept
  wire all_low_w  = !cs_n_w && !(hb_n_w && lb_n_w) && !ps_n_w && !we_n_w; // cs, cfg, we and at least one byte select down
  wire pin_end_w  = arm_ff && !all_low_w;
  wire rd_w       = !cs_n_w && ps_n_w && we_n_w && !oe_n_w; // ordinary read
  wire cs_rise_w  = !cs_d_ff && cs_n_w;    // end of a read cycle
  wire sw_match_w = (seq_ff < 3'h3) ? (addr_ff == `PSMC_MAGIC_A) : (addr_ff == `PSMC_MAGIC_B);
  wire sw_end_w   = cs_rise_w && rd_seen_ff && (seq_ff == `PSMC_MAGIC_CNT);
  wire stby_w     = cs_n_w && !ps_n_w && (pwr_ff == ST_STBY);
  wire lp_hit_w   = stby_w && (lp_cnt_ff >= LP_CYC);
  wire dpd_exit_w = (pwr_ff == ST_DPD) && ps_n_w;

  // pin load arming: latches in standby when chip select, cfg, write and either byte select are low
  // drops as soon as chip select, cfg or write rises, or both byte selects rise, which is what ends the load
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arm_ff <= 1'b0;
    end else if (all_low_w && (pwr_ff == ST_STBY)) begin
      arm_ff <= 1'b1;
    end else begin
      arm_ff <= 1'b0;
    end
  end

  // magic read counter: each read at the expected magic address ending on chip select high counts
  // a select period without output enable is not a read and restarts it
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_ff  <= 3'h0;
      cs_d_ff <= 1'b1;
    end else begin
      cs_d_ff <= cs_n_w;
      if (sw_end_w || !ps_n_w || !we_n_w) begin
        seq_ff <= 3'h0; // write or strobe breaks the sequence
      end else if (cs_rise_w) begin
        seq_ff <= (sw_match_w && rd_seen_ff) ? seq_ff + 3'h1 : 3'h0;
      end
    end
  end

  // read marker for the current select period
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_seen_ff <= 1'b0;
    end else if (cs_rise_w) begin
      rd_seen_ff <= 1'b0; // period over
    end else if (rd_w) begin
      rd_seen_ff <= 1'b1;
    end
  end

  // mode word register; reserved upper bits never stored
  // deep exit wins over a load, the controller must wake up first anyway
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_o  <= `PSMC_DEFAULT;
      load_ff <= 1'b0;
    end else begin
      load_ff <= 1'b0;
      if (dpd_exit_w) begin
        mode_o <= `PSMC_DEFAULT;
      end else if (pin_end_w || sw_end_w) begin
        mode_o  <= addr_ff[`PSMC_W_MODE-1:0];
        load_ff <= 1'b1;
      end
    end
  end

  // strobe-low timer in standby with chip deselected
  // saturates so a very long hold cannot wrap back below the limit
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lp_cnt_ff <= 8'h00;
    end else if (!stby_w) begin
      lp_cnt_ff <= 8'h00;
    end else if (lp_cnt_ff < LP_CYC) begin
      lp_cnt_ff <= lp_cnt_ff + 8'h01;
    end
  end

  // power state choice
  // deep sleep is tested first, which gives it priority over partial refresh
  always @* begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      ST_STBY: begin
        if (lp_hit_w && !mode_o[`PSMC_B_DSLEEP]) begin
          nxt_pwr = ST_DPD;
        end else if (lp_hit_w && !mode_o[`PSMC_B_RRET]) begin
          nxt_pwr = ST_PAR;
        end
      end
      ST_PAR:  if (ps_n_w) nxt_pwr = ST_STBY; // word kept
      ST_DPD:  if (ps_n_w) nxt_pwr = ST_STBY;
      default: nxt_pwr = ST_STBY;
    endcase
  end

  // power state and data-lost flag
  // set has priority, so a clear in the same cycle cannot hide data loss
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_ff  <= ST_STBY;
      lost_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      if (pwr_ff == ST_DPD) begin
        lost_ff <= 1'b1; // data gone
      end else if (load_ff) begin
        lost_ff <= 1'b0;
      end else if (!cs_n_w && !we_n_w) begin
        lost_ff <= 1'b0; // first write after wake clears
      end
    end
  end

  // ready delayed one clock for at-data timing
  // registered so the pin never glitches while the mode word is loaded
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdy_d_ff    <= 1'b0;
      ready_pin_o <= 1'b0;
    end else begin
      rdy_d_ff    <= data_ready_i;
      // early timing follows ready directly; at-data lags one clock
      ready_pin_o <= (mode_o[`PSMC_B_RDYTIM] ? rdy_d_ff : data_ready_i) ^ mode_o[`PSMC_B_RDYPOL];
    end
  end

  // field decode is purely combinational from the stored word
  psmc_decode u_dec (
    .mode_i      (mode_o),
    .latency_o   (latency_o),
    .burst_len_o (burst_len_o),
    .burst_cont_o(burst_cont_o),
    .drive_o     (drive_level_o),
    .mode_bad_o  (mode_bad_o)
  );

  assign first_access_style_o = mode_o[`PSMC_B_STYLE];
  assign operating_mode_sel_o = mode_o[`PSMC_B_OPM_HI:`PSMC_B_OPM_LO];
  assign wrap_o               = !mode_o[`PSMC_B_WRAP];
  assign ready_early_o        = !mode_o[`PSMC_B_RDYTIM];
  // refresh stops in deep sleep and during continuous bursts
  assign refresh_en_o   = (pwr_ff != ST_DPD) && !(burst_cont_o && burst_active_i);
  assign refresh_part_o = (pwr_ff == ST_PAR);
  assign refresh_region_o = (pwr_ff != ST_PAR || mode_o[`PSMC_B_SIZE_HI:`PSMC_B_SIZE_LO] == `PSMC_SZ_FULL) ?
                            2'h0 : (mode_o[`PSMC_B_HALF] ? 2'h2 : 2'h1);
  assign refresh_quarter_o = (mode_o[`PSMC_B_SIZE_HI:`PSMC_B_SIZE_LO] == `PSMC_SZ_QTR) ?
                             2'h1 : 2'h0; // quarter within chosen half
  assign partial_o     = (pwr_ff == ST_PAR);
  assign deep_o        = (pwr_ff == ST_DPD);
  assign data_lost_o   = lost_ff;
  assign config_load_o = load_ff;
endmodule // psmc_core

// file: psmc_core_asserts.sv
// port checker for the mode configuration core
`include "psmc_map.vh"
module psmc_chk (
  input logic        clk_sys_i,
  input logic        nrst_i,
  input logic        cfg_strobe_n_i,
  input logic        data_ready_i,
  input logic        burst_active_i,
  input logic [18:0] mode_o,
  input logic        first_access_style_o,
  input logic [1:0]  drive_level_o,
  input logic [1:0]  operating_mode_sel_o,
  input logic        wrap_o,
  input logic [3:0]  latency_o,
  input logic [5:0]  burst_len_o,
  input logic        burst_cont_o,
  input logic        ready_early_o,
  input logic        ready_pin_o,
  input logic        refresh_en_o,
  input logic [1:0]  refresh_region_o,
  input logic        refresh_quarter_o,
  input logic        refresh_part_o,
  input logic        partial_o,
  input logic        deep_o,
  input logic        config_load_o,
  input logic        mode_bad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  wire [2:0] lc = mode_o[11:9]; // latency code
  wire [2:0] bc = mode_o[7:5];  // burst code
  a_lat_map: assert property (latency_o == ((lc == 3'h4) ? 4'h2 : (lc < 3'h4) ? lc + 4'h3 : lc + 4'h2))
    else $error("latency count does not match code");
  a_len_map: assert property (burst_cont_o == (bc == 3'h7)
    && burst_len_o == ((bc >= 3'h2 && bc <= 3'h5) ? 6'h01 << bc : 6'h00)) else $error("burst length wrong");
  a_field_map: assert property (first_access_style_o == mode_o[18] && wrap_o == !mode_o[12]
    && operating_mode_sel_o == mode_o[15:14] && ready_early_o == !mode_o[8]
    && drive_level_o == ((mode_o[17:16] == 2'h3) ? 2'h0 : mode_o[17:16])) else $error("decoded field wrong");
  a_bad_code: assert property (mode_bad_o == (mode_o[17:16] == 2'h3 || mode_o[15] || bc < 3'h2 || bc == 3'h6
    || mode_o[1:0] == 2'h1)) else $error("reserved code flag wrong");
  a_cont_nref: assert property (burst_cont_o && burst_active_i |-> !refresh_en_o)
    else $error("refresh during continuous burst");
  a_deep_quiet: assert property (deep_o |-> !refresh_en_o && !partial_o)
    else $error("refresh or partial in deep sleep");
  a_lp_entry: assert property ($rose(deep_o) || $rose(partial_o) |-> $past(cfg_strobe_n_i, 5) == 1'b0
    && deep_o == !mode_o[4] && partial_o == (mode_o[4] && !mode_o[3])) else $error("low power entry wrong");
  a_mode_cause: assert property (!$stable(mode_o) |-> config_load_o || $fell(deep_o))
    else $error("mode word changed without load");
  a_deep_dflt: assert property ($fell(deep_o) |-> mode_o == `PSMC_DEFAULT && !config_load_o)
    else $error("deep exit without default word");
  a_rdy_early: assert property (!mode_o[8] && $stable(mode_o)
    |-> ready_pin_o == ($past(data_ready_i) ^ mode_o[13])) else $error("valid indicator wrong");
  a_rdy_late: assert property (mode_o[8] && $stable(mode_o)
    |-> ready_pin_o == ($past(data_ready_i, 2) ^ mode_o[13])) else $error("late valid indicator wrong");
  a_region_map: assert property (refresh_part_o == partial_o && refresh_quarter_o == (mode_o[1:0] == 2'h3)
    && refresh_region_o == ((!partial_o || mode_o[1:0] == 2'h0) ? 2'h0 : (mode_o[2] ? 2'h2 : 2'h1)))
    else $error("retained region wrong");
endmodule // psmc_chk
bind psmc_core psmc_chk psmc_chk_i (.clk_sys_i, .nrst_i, .cfg_strobe_n_i, .data_ready_i, .burst_active_i, .mode_o,
  .first_access_style_o, .drive_level_o, .operating_mode_sel_o, .wrap_o, .latency_o, .burst_len_o, .burst_cont_o,
  .ready_early_o, .ready_pin_o, .refresh_en_o, .refresh_region_o, .refresh_quarter_o, .refresh_part_o, .partial_o,
  .deep_o, .config_load_o, .mode_bad_o);

// file: psmc_ctl.sv
// memory controller model driving load and low-power pin sequences
`include "psmc_map.vh"
module psmc_ctl (
  input  logic        clk_sys_i,
  output logic [23:0] addr_o,
  output logic        cs_n_o,
  output logic        bs_n_o,  // both byte selects
  output logic        cfg_n_o,
  output logic        we_n_o,
  output logic        oe_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: strobes high
  initial begin
    {addr_o, cs_n_o, bs_n_o, cfg_n_o, we_n_o, oe_n_o} = {24'h000000, 5'h1F};
  end
  // automatic so parallel callers do not share the count
  task automatic tk(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // one read; cs low only 400 ns, well inside the refresh limit
  task automatic rd(input logic [23:0] a);
    tk(1);
    addr_o = a;
    {cs_n_o, bs_n_o, oe_n_o} = 3'h0;
    tk(4);
    {cs_n_o, bs_n_o, oe_n_o} = 3'h7;
    tk(3);
    addr_o = ~a; // hold over, no stale value
    tk(2);
  endtask
  // magic reads, then the word
  task automatic sw_load(input logic [23:0] a);
    repeat (3) rd(`PSMC_MAGIC_A);
    rd(`PSMC_MAGIC_B);
    rd(a);
  endtask
  // strobes fall in turn; k picks the strobe that ends it
  task automatic pin_load(input logic [23:0] a, input logic k);
    tk(1);
    addr_o = a;
    for (int j = 0; j < 4; j++) begin
      tk(1);
      {we_n_o, cfg_n_o, bs_n_o, cs_n_o} = 4'hE << j;
    end
    tk(4);
    if (k) cfg_n_o = 1'b1;
    else we_n_o = 1'b1;
    tk(1);
    {we_n_o, cfg_n_o, bs_n_o, cs_n_o} = 4'hF;
    tk(3);
    addr_o = ~a;
  endtask
  // standby with cfg low n clocks
  task automatic lp(input int n);
    tk(1);
    cfg_n_o = 1'b0;
    tk(n);
    cfg_n_o = 1'b1;
    tk(4);
  endtask
endmodule // psmc_ctl

// file: tb_top.sv
// self-checking bench for the mode configuration core
`include "psmc_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i, nrst_i, data_ready_i, burst_active_i;
  logic [23:0] addr;
  logic        cs_n, bs_n, cfg_n, we_n, oe_n;
  logic [18:0] mode_o, cur, w;  // stored, expected, next word
  logic [3:0]  latency_o;
  logic [5:0]  burst_len_o;
  logic        partial_o, deep_o, data_lost_o, refresh_en_o, config_load_o;
  logic [31:0] rnd, rr;
  logic [2:0]  bt [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7};  // legal burst codes
  integer      seed = 99113;
  integer      errors = 0;
  integer      n_checks = 0;
  psmc_ctl psmc_ctl_i (.clk_sys_i, .addr_o(addr), .cs_n_o(cs_n), .bs_n_o(bs_n), .cfg_n_o(cfg_n), .we_n_o(we_n),
    .oe_n_o(oe_n));
  psmc_core psmc_core_i (.clk_sys_i, .nrst_i, .addr_i(addr), .chip_select_n_i(cs_n), .high_byte_sel_n_i(bs_n),
    .low_byte_sel_n_i(bs_n), .cfg_strobe_n_i(cfg_n), .write_strobe_n_i(we_n), .out_enable_n_i(oe_n),
    .data_ready_i, .burst_active_i, .mode_o, .first_access_style_o(), .drive_level_o(), .operating_mode_sel_o(),
    .wrap_o(), .latency_o, .burst_len_o, .burst_cont_o(), .ready_early_o(), .ready_pin_o(), .refresh_en_o,
    .refresh_region_o(), .refresh_quarter_o(), .refresh_part_o(), .partial_o, .deep_o, .data_lost_o,
    .config_load_o, .mode_bad_o());
  // 10 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // random datapath inputs, ready quiet in reset
  always @(negedge clk_sys_i) begin
    rr = $random(seed);
    data_ready_i <= nrst_i & rr[0];
    burst_active_i <= rr[1];
  end
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #500000;
    errors = errors + 1;
    close_out;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // bounded wait for the load pulse, then compare with the model
  task wload;
    int k;
    k = 0;
    while (config_load_o !== 1'b1 && k < 90) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk({config_load_o, mode_o}, {1'b1, cur});
    chk(latency_o, (cur[11:9] == 3'h4) ? 2 : cur[11:9] + 3 - (cur[11:9] > 3'h4));
    chk(burst_len_o, (cur[7:5] inside {[3'h2:3'h5]}) ? 1 << cur[7:5] : 0);
  endtask
  // k 0 or 1: pin load, 2: read sequence; junk in bits 23..19
  task ld(input logic [18:0] wd, input int k);
    rnd = $random(seed);
    cur = wd;
    fork
      if (k == 2) psmc_ctl_i.sw_load({rnd[23:19], wd});
      else psmc_ctl_i.pin_load({rnd[23:19], wd}, k[0]);
      wload;
    join
  endtask
  // cfg held low n clocks, state looked at after `at` clocks
  task hold(input int n, input int at, input logic p, input logic d);
    fork
      psmc_ctl_i.lp(n);
      begin
        repeat (at) @(negedge clk_sys_i);
        chk({partial_o, deep_o, refresh_en_o, data_lost_o}, {p, d, !d, d});
      end
    join
    chk({partial_o, deep_o}, 2'h0);
  endtask
  initial begin
    nrst_i = 1'b0;
    psmc_ctl_i.tk(12);
    nrst_i = 1'b1;
    chk(mode_o, `PSMC_DEFAULT);
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      w = {rnd[18], 2'(i % 3), 1'b0, rnd[14:12], i[2:0], rnd[8], bt[i % 5], 2'h3, rnd[2:0]};
      ld(w, i % 3);
    end
    $display("test loads done");
    nrst_i = 1'b0;
    psmc_ctl_i.tk(2);
    nrst_i = 1'b1;
    cur = `PSMC_DEFAULT;
    chk(mode_o, cur);
    repeat (4) psmc_ctl_i.rd(`PSMC_MAGIC_A);
    psmc_ctl_i.rd(24'h012345);
    chk(mode_o, cur);
    $display("test reset and bad sequence done");
    ld(19'h00056, 0);
    hold(14, 12, 1'b1, 1'b0);
    chk(mode_o, cur);
    ld(19'h0004C, 1);
    hold(4, 7, 1'b0, 1'b0);
    hold(14, 12, 1'b0, 1'b1);
    chk(mode_o, `PSMC_DEFAULT);
    $display("test low power done");
    close_out;
  end
endmodule // tb_top
